// ### rcsp_params.svh
// constants for the read-channel serial control port
`ifndef RCSP_PARAMS_SVH
`define RCSP_PARAMS_SVH
`define RCSP_ADDR_CTRL_A      7'h1A
`define RCSP_ADDR_CTRL_B      7'h0C
`define RCSP_CTRL_A_RESET     8'h00
`define RCSP_CTRL_B_RESET     8'h00
`define RCSP_FRAME_BITS       5'h10
`define RCSP_HDR_BITS         5'h08
`define RCSP_BIT_SYNTH_PD     0
`define RCSP_BIT_SYNTH_UP     1
`define RCSP_BIT_SYNTH_DN     2
`define RCSP_BIT_SYNTH_EN     3
`define RCSP_BIT_SYNTH_BYP    4
`define RCSP_BIT_PULSE_DETECT_TEST_ENABLE      5
`define RCSP_BIT_AGC_FAST     6
`define RCSP_BIT_ENDEC_BYP    0
`define RCSP_BIT_GAIN_SW      1
`define RCSP_BIT_RD_PIN       2
`define RCSP_BIT_SEP_PD       3
`define RCSP_BIT_SEP_UP       4
`define RCSP_BIT_SEP_DN       5
`define RCSP_BIT_SEP_TP       6
`define RCSP_BIT_SOFT_SECTOR  7
`define RCSP_SCK_HALF         8'h04
`define RCSP_OFF_CMD          12'h000
`define RCSP_OFF_WDATA        12'h004
`define RCSP_OFF_STATUS       12'h008
`define RCSP_OFF_RDATA        12'h00C
`endif

// ### rcsp_pkg.sv
// types shared by both ends of the serial control port
package rcsp_pkg;
  typedef logic [6:0] rcsp_addr_t;
  typedef logic [7:0] rcsp_byte_t;
  typedef enum logic [3:0] {
    RCSP_IDLE  = 4'b0001,
    RCSP_SETUP = 4'b0010,
    RCSP_SHIFT = 4'b0100,
    RCSP_END   = 4'b1000
  } rcsp_state_e;
endpackage

// ### rcsp_if.sv
// link between host controller and device port
`timescale 1ns/1ps
interface rcsp_if;
  logic sel;
  logic sck;
  logic host_dout;
  logic host_oe_n;
  logic dev_dout;
  logic dev_oe_n;
  logic sdio;
  assign sdio = !host_oe_n ? host_dout : (!dev_oe_n ? dev_dout : 1'b1);
  modport host (output sel, output sck, output host_dout, output host_oe_n, input sdio);
  modport dev  (input sel, input sck, input sdio, output dev_dout, output dev_oe_n);
endinterface

// ### rcsp_sync.sv
// two-flop synchroniser for the link pins
`timescale 1ns/1ps
module rcsp_sync (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // rcsp_sync

// ### rcsp_dev.sv
// device end: serial port and the two control registers
`timescale 1ns/1ps
`include "rcsp_params.svh"
module rcsp_dev (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  rcsp_if.dev       link,
  input  wire logic pulse_detect_raw,
  output logic      synth_phase_detector_enable,
  output logic      synth_pump_source_test,
  output logic      synth_pump_sink_test,
  output logic      synth_circuit_enable,
  output logic      synth_bypass,
  output logic      pulse_detect_test_enable,
  output logic      agc_fast_decay_force,
  output logic      endec_bypass_write,
  output logic      phase_gain_switch_enable,
  output logic      read_pin_input_mode,
  output logic      sep_phase_detector_enable,
  output logic      sep_pump_source_test,
  output logic      sep_pump_sink_test,
  output logic      sep_test_point_outputs,
  output logic      soft_sector_select,
  output logic      pulse_detect_out
);
  import rcsp_pkg::*;

  typedef struct packed {
    logic       sck_last;
    logic [4:0] cnt;
    logic       over;
    logic       rd;
    logic [15:0] shreg;
    rcsp_byte_t ctrl_a;
    rcsp_byte_t ctrl_b;
    rcsp_byte_t rd_sh;
    logic       dout;
    logic       oe_n;
    logic       pulse_out;
  } rcsp_dev_s;

  rcsp_dev_s s_q;
  rcsp_dev_s s_d;
  logic      sel_s;
  logic      sck_s;
  logic      sdi_s;
  logic      pulse_s;

  // port runs on core clock only, no power-down gating
  // equal sync depth on all three pins keeps the data bit aligned with its edge
  rcsp_sync u_sel (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (link.sel),
    .sync_out (sel_s)
  );

  rcsp_sync u_sck (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (link.sck),
    .sync_out (sck_s)
  );

  rcsp_sync u_sdi (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (link.sdio),
    .sync_out (sdi_s)
  );

  // pulse pin is asynchronous to the core clock as well
  rcsp_sync u_pulse (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pulse_detect_raw),
    .sync_out (pulse_s)
  );

  function automatic rcsp_byte_t reg_read(input rcsp_addr_t a, input rcsp_byte_t ra,
                                          input rcsp_byte_t rb);
    rcsp_byte_t v;
    v = 8'h00;
    if (a == `RCSP_ADDR_CTRL_A) begin
      v = ra;
    end else if (a == `RCSP_ADDR_CTRL_B) begin
      v = rb;
    end
    return v;
  endfunction

  always_comb begin
    logic       rise;
    logic       fall;
    logic [15:0] nsh;
    s_d  = s_q;
    rise = sck_s && !s_q.sck_last;
    fall = !sck_s && s_q.sck_last;
    nsh  = {sdi_s, s_q.shreg[15:1]};
    s_d.sck_last = sck_s;
    if (!sel_s) begin
      // commit only on deselect with a full, clean write frame
      // rd guard: a read leaves stale low bits that could pass as a write
      if (s_q.cnt == `RCSP_FRAME_BITS && !s_q.over && !s_q.rd && !s_q.shreg[0]) begin
        if (s_q.shreg[7:1] == `RCSP_ADDR_CTRL_A) begin
          s_d.ctrl_a = s_q.shreg[15:8];
        end else if (s_q.shreg[7:1] == `RCSP_ADDR_CTRL_B) begin
          s_d.ctrl_b = s_q.shreg[15:8];
        end
      end
      s_d.cnt  = 5'h00;
      s_d.over = 1'b0;
      s_d.rd   = 1'b0;
      s_d.oe_n = 1'b1;
    end else begin
      if (rise && s_q.oe_n) begin
        s_d.shreg = nsh;
        if (s_q.cnt == `RCSP_FRAME_BITS) begin
          s_d.over = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 5'h01;
        end
        // flag lands in bit 8 after eight shifts; latch it, fetch the byte
        if (s_q.cnt == `RCSP_HDR_BITS - 5'h01) begin
          s_d.rd = nsh[8];
          if (nsh[8]) begin
            s_d.rd_sh = reg_read(nsh[15:9], s_q.ctrl_a, s_q.ctrl_b);
          end
        end
      end else if (rise) begin
        // pin is driven here: count only, a 17th edge hands it back
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == `RCSP_FRAME_BITS) begin
          s_d.oe_n = 1'b1;
          s_d.cnt  = s_q.cnt;
        end
      end
      // drive next bit on falling edge; host samples it on the next falling edge
      if (fall && s_q.cnt >= `RCSP_HDR_BITS && s_q.cnt < `RCSP_FRAME_BITS &&
          s_q.rd) begin
        s_d.oe_n  = 1'b0;
        s_d.dout  = s_q.rd_sh[0];
        s_d.rd_sh = {1'b0, s_q.rd_sh[7:1]};
      end
      // writes never drive the pin
      if (!s_q.rd) begin
        s_d.oe_n = 1'b1;
      end
    end
    // pulse pin output gated by test bit
    s_d.pulse_out = pulse_s && !s_q.ctrl_a[`RCSP_BIT_PULSE_DETECT_TEST_ENABLE];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // blanket clear first, then the parts with their own reset value
      s_q        <= '0;
      s_q.ctrl_a <= `RCSP_CTRL_A_RESET;
      s_q.ctrl_b <= `RCSP_CTRL_B_RESET;
      s_q.oe_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // pin drive comes straight from flops, so the shared wire never glitches
  assign link.dev_dout = s_q.dout;
  assign link.dev_oe_n = s_q.oe_n;
  assign synth_phase_detector_enable = s_q.ctrl_a[`RCSP_BIT_SYNTH_PD];
  assign synth_pump_source_test      = s_q.ctrl_a[`RCSP_BIT_SYNTH_UP];
  assign synth_pump_sink_test        = s_q.ctrl_a[`RCSP_BIT_SYNTH_DN];
  assign synth_circuit_enable        = s_q.ctrl_a[`RCSP_BIT_SYNTH_EN];
  assign synth_bypass                = s_q.ctrl_a[`RCSP_BIT_SYNTH_BYP];
  assign pulse_detect_test_enable    = s_q.ctrl_a[`RCSP_BIT_PULSE_DETECT_TEST_ENABLE];
  assign agc_fast_decay_force        = s_q.ctrl_a[`RCSP_BIT_AGC_FAST];
  assign endec_bypass_write          = s_q.ctrl_b[`RCSP_BIT_ENDEC_BYP];
  assign phase_gain_switch_enable    = s_q.ctrl_b[`RCSP_BIT_GAIN_SW];
  assign read_pin_input_mode         = s_q.ctrl_b[`RCSP_BIT_RD_PIN];
  assign sep_phase_detector_enable   = s_q.ctrl_b[`RCSP_BIT_SEP_PD];
  assign sep_pump_source_test        = s_q.ctrl_b[`RCSP_BIT_SEP_UP];
  assign sep_pump_sink_test          = s_q.ctrl_b[`RCSP_BIT_SEP_DN];
  assign sep_test_point_outputs      = s_q.ctrl_b[`RCSP_BIT_SEP_TP];
  assign soft_sector_select          = s_q.ctrl_b[`RCSP_BIT_SOFT_SECTOR];
  assign pulse_detect_out            = s_q.pulse_out;
endmodule // rcsp_dev

// ### rcsp_host.sv
// host end: apb-controlled serial frame generator
`timescale 1ns/1ps
`include "rcsp_params.svh"
module rcsp_host (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  rcsp_if.host             link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import rcsp_pkg::*;

  typedef struct packed {
    rcsp_state_e st;
    logic [15:0] frame;
    logic        rd;
    logic [4:0]  bitn;
    logic [7:0]  div;
    logic        sck;
    logic        sel;
    logic        dout;
    logic        oe_n;
    rcsp_byte_t  rdata;
    logic [6:0]  cmd_addr;
    logic        cmd_rd;
    rcsp_byte_t  wdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rcsp_host_s;

  rcsp_host_s s_q;
  rcsp_host_s s_d;
  logic       sdi_s;

  rcsp_sync u_sdi (.core_clk(core_clk), .sys_rst(sys_rst), .async_in(link.sdio), .sync_out(sdi_s));

  always_comb begin
    logic acc;
    s_d = s_q;
    acc = psel && penable && !s_q.pready;
    s_d.pready  = acc;
    s_d.pslverr = 1'b0;
    if (acc) begin
      s_d.prdata = 32'h0000_0000;
      if (paddr == `RCSP_OFF_CMD) begin
        if (pwrite && s_q.st == RCSP_IDLE) begin
          s_d.cmd_addr = pwdata[6:0];
          s_d.cmd_rd   = pwdata[7];
          s_d.frame    = {s_q.wdata, pwdata[6:0], pwdata[7]};
          s_d.rd       = pwdata[7];
          s_d.st       = RCSP_SETUP;
          s_d.div      = 8'h00;
          s_d.sel      = 1'b1;
        end
        s_d.prdata = {24'h0, s_q.cmd_rd, s_q.cmd_addr};
      end else if (paddr == `RCSP_OFF_WDATA) begin
        if (pwrite) begin
          s_d.wdata = pwdata[7:0];
        end
        s_d.prdata = {24'h0, s_q.wdata};
      end else if (paddr == `RCSP_OFF_STATUS) begin
        s_d.prdata = {31'h0, s_q.st != RCSP_IDLE};
      end else if (paddr == `RCSP_OFF_RDATA) begin
        s_d.prdata = {24'h0, s_q.rdata};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    case (s_q.st)
      RCSP_IDLE: begin
        s_d.sel  = s_d.sel;
        s_d.oe_n = 1'b1;
      end
      RCSP_SETUP: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == `RCSP_SCK_HALF) begin
          s_d.div  = 8'h00;
          s_d.bitn = 5'h00;
          s_d.dout = s_q.frame[0];
          s_d.oe_n = 1'b0;
          s_d.st   = RCSP_SHIFT;
        end
      end
      RCSP_SHIFT: begin
        // gated clock: toggles only inside the frame
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == `RCSP_SCK_HALF) begin
          s_d.div = 8'h00;
          s_d.sck = !s_q.sck;
          if (s_q.sck) begin
            // sample at the falling edge: both sync chains and the device's
            // drive flop eat the low phase, so the rising edge sees the old bit
            if (s_q.rd && s_q.bitn >= `RCSP_HDR_BITS) begin
              s_d.rdata = {sdi_s, s_q.rdata[7:1]};
            end
            s_d.bitn = s_q.bitn + 5'h01;
            if (s_q.bitn == `RCSP_FRAME_BITS - 5'h01) begin
              s_d.st   = RCSP_END;
              s_d.oe_n = 1'b1;
            end else begin
              s_d.dout  = s_q.frame[s_q.bitn[3:0] + 4'h1];
              // release pin after header on reads
              s_d.oe_n  = s_q.rd && (s_q.bitn >= `RCSP_HDR_BITS - 5'h01);
            end
          end
        end
      end
      RCSP_END: begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == `RCSP_SCK_HALF) begin
          s_d.sel = 1'b0;
          s_d.st  = RCSP_IDLE;
        end
      end
      default: begin
        s_d.st = RCSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.st   <= RCSP_IDLE;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sel       = s_q.sel;
  assign link.sck       = s_q.sck;
  assign link.host_dout = s_q.dout;
  assign link.host_oe_n = s_q.oe_n;
  assign prdata         = s_q.prdata;
  assign pready         = s_q.pready;
  assign pslverr        = s_q.pslverr;
endmodule // rcsp_host

// ### rcsp_monitor.sv
// assertions on the serial link between host and device ends
`timescale 1ns/1ps
module rcsp_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sel,
  input wire logic sck,
  input wire logic host_dout,
  input wire logic host_oe_n,
  input wire logic dev_dout,
  input wire logic dev_oe_n,
  input wire logic sdio
);
  logic [4:0] cnt_q;
  logic       rd_q;
  logic       sck_q;
  logic       sel_q;
  // rising serial clocks in the current frame, held after select drops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
      rd_q  <= 1'b0;
      sck_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sck_q <= sck;
      sel_q <= sel;
      if (sel && !sel_q) begin
        cnt_q <= 5'h00;
      end else if (sel && sck && !sck_q) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h00) begin
          rd_q <= sdio;
        end
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_sck_gated: assert property ($rose(sck) |-> sel)
    else $error("serial clock rose outside a frame");
  a_sck_width: assert property ($rose(sck) |-> sck [*4] ##[1:2] !sck)
    else $error("serial clock high time wrong");
  a_no_contention: assert property (host_oe_n || dev_oe_n)
    else $error("both ends drive the data pin");
  a_write_no_drive: assert property ((cnt_q != 5'h00 && !rd_q) |-> dev_oe_n)
    else $error("device drove pin in a write frame");
  a_read_turn: assert property (!dev_oe_n |-> rd_q && cnt_q >= 5'h08)
    else $error("device drove pin before the address ended");
  a_host_releases: assert property ((rd_q && sel && cnt_q >= 5'h09) |-> host_oe_n)
    else $error("host still drives during read data");
  a_frame_len: assert property ($fell(sel) |-> cnt_q == 5'h10)
    else $error("frame not sixteen clocks long");
  a_release_idle: assert property (!sel [*6] |-> dev_oe_n)
    else $error("device holds pin after select dropped");
endmodule // rcsp_monitor

// ### testbench.sv
// self-checking bench: host and device ends plus a bench-driven device
`timescale 1ns/1ps
`include "rcsp_params.svh"
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module testbench;
  import rcsp_pkg::*;
  logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr, raw, pdo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  oa, oa2;
  logic [7:0]  ob;
  rcsp_byte_t  ea, eb, d;
  int          n_errors, num_checks;
  rcsp_if lnk();
  rcsp_if lnk2();
  rcsp_host rcsp_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rcsp_dev rcsp_dev_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk.dev),
    .pulse_detect_raw(raw), .synth_phase_detector_enable(oa[0]),
    .synth_pump_source_test(oa[1]), .synth_pump_sink_test(oa[2]),
    .synth_circuit_enable(oa[3]), .synth_bypass(oa[4]), .pulse_detect_test_enable(oa[5]),
    .agc_fast_decay_force(oa[6]), .endec_bypass_write(ob[0]),
    .phase_gain_switch_enable(ob[1]), .read_pin_input_mode(ob[2]),
    .sep_phase_detector_enable(ob[3]), .sep_pump_source_test(ob[4]),
    .sep_pump_sink_test(ob[5]), .sep_test_point_outputs(ob[6]),
    .soft_sector_select(ob[7]), .pulse_detect_out(pdo));
  // second device, driven by the bench to break framing on purpose
  rcsp_dev rcsp_dev_b_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk2.dev),
    .pulse_detect_raw(raw), .synth_phase_detector_enable(oa2[0]),
    .synth_pump_source_test(oa2[1]), .synth_pump_sink_test(oa2[2]),
    .synth_circuit_enable(oa2[3]), .synth_bypass(oa2[4]),
    .pulse_detect_test_enable(oa2[5]), .agc_fast_decay_force(oa2[6]),
    .endec_bypass_write(), .phase_gain_switch_enable(), .read_pin_input_mode(),
    .sep_phase_detector_enable(), .sep_pump_source_test(), .sep_pump_sink_test(),
    .sep_test_point_outputs(), .soft_sector_select(), .pulse_detect_out());
  rcsp_monitor rcsp_monitor_inst (.core_clk(core_clk), .sys_rst(sys_rst), .sel(lnk.sel),
    .sck(lnk.sck), .host_dout(lnk.host_dout), .host_oe_n(lnk.host_oe_n),
    .dev_dout(lnk.dev_dout), .dev_oe_n(lnk.dev_oe_n), .sdio(lnk.sdio));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic exp_pd(input logic rw, input rcsp_byte_t a);
    return rw & ~a[`RCSP_BIT_PULSE_DETECT_TEST_ENABLE];
  endfunction
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // waits on pready without assuming a latency; the watchdog bounds it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xfer(input logic rd, input rcsp_addr_t a, input rcsp_byte_t wd);
    apb(1'b1, `RCSP_OFF_WDATA, {24'h0, wd});
    apb(1'b1, `RCSP_OFF_CMD, {24'h0, rd, a});
    repeat (2) @(posedge core_clk);
    r = 32'h1;
    while (r[0] !== 1'b0) apb(1'b0, `RCSP_OFF_STATUS, 32'h0);
    repeat (8) @(posedge core_clk);
    apb(1'b0, `RCSP_OFF_RDATA, 32'h0);
  endtask
  // 320 ns serial clock, only inside the frame; host lets go after hdr bits
  task automatic rogue(input logic [16:0] v, input int n, input int hdr);
    @(posedge core_clk);
    lnk2.sel <= 1'b1;
    for (int i = 0; i < n; i++) begin
      lnk2.host_oe_n <= (i >= hdr);
      lnk2.host_dout <= v[i];
      repeat (4) @(posedge core_clk);
      lnk2.sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      lnk2.sck <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic drop;
    lnk2.sel <= 1'b0;
    lnk2.host_oe_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    stop_test;
  end
  initial begin
    {psel, penable, pwrite, raw, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    {lnk2.sel, lnk2.sck, lnk2.host_dout, lnk2.host_oe_n} = 4'b0001;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(32'hB425));
    repeat (10) @(posedge core_clk);
    `CHK("reset_b", 8'h00, ob)
    sys_rst <= 1'b0;
    // software sets fast decay first, as at power-up
    xfer(1'b0, `RCSP_ADDR_CTRL_A, 8'h40);
    `CHK("fast_decay", 1'b1, oa[`RCSP_BIT_AGC_FAST])
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rcsp_byte_t'($urandom);
      xfer(1'b0, `RCSP_ADDR_CTRL_A, d);
      ea = d;
      xfer(1'b0, `RCSP_ADDR_CTRL_B, ~d);
      eb = ~d;
      `CHK("ctrl_a_out", ea[6:0], oa)
      `CHK("ctrl_b_out", eb, ob)
      xfer(1'b1, `RCSP_ADDR_CTRL_A, 8'h00);
      `CHK("ctrl_a_read", ea, r[7:0])
      xfer(1'b1, `RCSP_ADDR_CTRL_B, 8'h00);
      `CHK("ctrl_b_read", eb, r[7:0])
      raw <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      `CHK("pulse_out", exp_pd(raw, ea), pdo)
    end
    // a write to an address outside the two registers must leave both alone
    xfer(1'b0, 7'h02, 8'h5A);
    `CHK("stray_a", ea[6:0], oa)
    `CHK("stray_b", eb, ob)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("apb_err", 1'b1, perr)
    rogue({1'b1, 8'hA5, `RCSP_ADDR_CTRL_A, 1'b0}, 17, 17);
    drop();
    `CHK("extra_clock", 7'h00, oa2)
    rogue({1'b0, 8'hA5, `RCSP_ADDR_CTRL_A, 1'b0}, 16, 16);
    repeat (8) @(posedge core_clk);
    `CHK("before_drop", 7'h00, oa2)
    drop();
    `CHK("after_drop", 7'h25, oa2)
    rogue({9'h000, `RCSP_ADDR_CTRL_A, 1'b1}, 10, 8);
    `CHK("read_drive", 1'b0, lnk2.dev_oe_n)
    drop();
    `CHK("early_release", 1'b1, lnk2.dev_oe_n)
    stop_test;
  end
endmodule // testbench
